// ===== core/tl_link_pkg.sv
// constants, register map and state types for the touch-to-light link block
package tl_link_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 10;
	localparam int          DATA_W      = 32;
	localparam int          REG_W       = 8;
	localparam int          NUM_CH      = 11;
	localparam int          NUM_LINK    = 10;
	localparam int          NUM_SENSE   = 7;
	localparam int          NUM_GPIO    = 8;

	// ------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_LTRAN_A = 8'h77;
	localparam logic [7:0]  IDX_LTRAN_B = 8'h78;
	localparam logic [7:0]  IDX_MIR_A   = 8'h79;
	localparam logic [7:0]  IDX_MIR_B   = 8'h7a;
	localparam logic [7:0]  IDX_CFG     = 8'h7b;
	localparam logic [7:0]  IDX_LINK    = 8'h80;

	// ------------------------------------------------------------
	// writable bit masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  MASK_LTRAN_A = 8'h7f;
	localparam logic [7:0]  MASK_LTRAN_B = 8'h03;
	localparam logic [7:0]  MASK_MIR_A   = 8'hff;
	localparam logic [7:0]  MASK_MIR_B   = 8'h07;
	localparam logic [7:0]  MASK_CFG     = 8'h03;
	localparam logic [7:0]  MASK_LINK    = 8'hff;
	localparam logic [7:0]  RST_REG      = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          CFG_INV_BIT    = 0;
	localparam int          CFG_BLOCK_BIT  = 1;
	localparam int          LINK_GROUP_BIT = 7;
	localparam int          CH_LED8        = 7;
	localparam int          CH_LED9        = 8;
	localparam int          CH_LED10       = 9;
	localparam int          CH_LED11       = 10;

	// ------------------------------------------------------------
	// state of the link block
	// ------------------------------------------------------------
	typedef struct packed {
		logic [REG_W-1:0]    ltranA;
		logic [REG_W-1:0]    ltranB;
		logic [REG_W-1:0]    mirA;
		logic [REG_W-1:0]    mirB;
		logic [REG_W-1:0]    cfg;
		logic [REG_W-1:0]    link;
		logic [NUM_LINK-1:0] holdMode;
		logic [NUM_LINK-1:0] linkPrev;
		logic                lastUp;
		logic [NUM_CH-1:0]   actuate;
		logic [NUM_LINK-1:0] autoEn;
		logic [REG_W-1:0]    rdata;
		logic                ready;
		logic                slvErr;
	} link_state_t;

	// word address of an apb byte address
	function automatic logic [7:0] wordIdx(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

endpackage

// ===== core/tl_sync2.sv
// two-stage synchroniser for detector levels arriving from outside the clock
`timescale 1ns/1ps
module tl_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         clkEn,
	// levels
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = asyncIn;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign syncOut = st_r.s2;

endmodule

// ===== core/touch_led_link_control.sv
// touch sensor to light channel link, handover and duty mirror control
`timescale 1ns/1ps
module touch_led_link_control
	import tl_link_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                nrst,
	input  wire logic                clkEn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [DATA_W-1:0]   pwdata,
	output logic      [DATA_W-1:0]   prdata,
	output logic                     pready,
	output logic                     pslverr,
	// host side controls from the output and polarity registers
	input  wire logic [NUM_CH-1:0]   hostOutputBit,
	input  wire logic [NUM_CH-1:0]   polarityWrite,
	input  wire logic [NUM_CH-1:0]   outputPolarityBit,
	input  wire logic [NUM_GPIO-1:0] chanIsInput,
	// sensor detections
	input  wire logic [NUM_SENSE-1:0] sensorTouch,
	input  wire logic                groupUp,
	input  wire logic                groupDown,
	// towards the waveform drivers
	output logic      [NUM_CH-1:0]   actuate,
	output logic      [NUM_LINK-1:0] autoEnable,
	output logic      [NUM_CH-1:0]   dutyMirrorBit
);

	// ------------------------------------------------------------
	// detector synchronisation
	// ------------------------------------------------------------
	logic [NUM_SENSE+1:0] detSync;

	tl_sync2 #(
		.W       (NUM_SENSE + 2)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.asyncIn ({groupDown, groupUp, sensorTouch}),
		.syncOut (detSync)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	link_state_t st_r;
	link_state_t st_nxt;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic isMapped(input logic [7:0] idx);
		return (idx == IDX_LTRAN_A) || (idx == IDX_LTRAN_B) || (idx == IDX_MIR_A) ||
			(idx == IDX_MIR_B) || (idx == IDX_CFG) || (idx == IDX_LINK);
	endfunction

	function automatic logic [REG_W-1:0] readReg(input link_state_t s, input logic [7:0] idx);
		case (idx)
			IDX_LTRAN_A: return s.ltranA & MASK_LTRAN_A;
			IDX_LTRAN_B: return s.ltranB & MASK_LTRAN_B;
			IDX_MIR_A:   return s.mirA & MASK_MIR_A;
			IDX_MIR_B:   return s.mirB & MASK_MIR_B;
			IDX_CFG:     return s.cfg & MASK_CFG;
			IDX_LINK:    return s.link & MASK_LINK;
			default:     return RST_REG;
		endcase
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [7:0]          idx;
	logic                accessPh;
	logic                wrNow;
	logic [REG_W-1:0]    wByte;
	logic [NUM_CH-1:0]   mirNow;
	logic [NUM_LINK-1:0] ltran;
	logic [NUM_LINK-1:0] linkEff;
	logic [NUM_LINK-1:0] touch;
	logic [NUM_LINK-1:0] rise;
	logic [NUM_CH-1:0]   act;
	logic                invFlag;
	logic                blockFollow;
	logic                grpLinked;

	always_comb begin
		st_nxt   = st_r;
		idx      = wordIdx(paddr);
		accessPh = psel && penable;
		wrNow    = accessPh && st_r.ready && pwrite && isMapped(idx);
		wByte    = pwdata[REG_W-1:0];

		// apb: one wait state, then answer for one cycle
		st_nxt.ready = accessPh && !st_r.ready;
		if (accessPh && !st_r.ready) begin
			st_nxt.slvErr = !isMapped(idx);
			st_nxt.rdata  = pwrite ? RST_REG : readReg(st_r, idx);
		end else begin
			st_nxt.slvErr = 1'b0;
		end

		// register writes take effect at the completing edge
		if (wrNow) begin
			case (idx)
				IDX_LTRAN_A: st_nxt.ltranA = wByte & MASK_LTRAN_A;
				IDX_LTRAN_B: st_nxt.ltranB = wByte & MASK_LTRAN_B;
				IDX_MIR_A:   st_nxt.mirA = wByte & MASK_MIR_A;
				IDX_MIR_B:   st_nxt.mirB = wByte & MASK_MIR_B;
				IDX_CFG:     st_nxt.cfg = wByte & MASK_CFG;
				IDX_LINK:    st_nxt.link = wByte & MASK_LINK;
				default:     st_nxt.cfg = st_r.cfg;
			endcase
		end

		invFlag     = st_r.cfg[CFG_INV_BIT];
		blockFollow = st_r.cfg[CFG_BLOCK_BIT];

		// polarity writes copy into mirror bits unless the cfg block bit is set; hardware copy wins a same-cycle write
		mirNow = {st_nxt.mirB[NUM_CH-NUM_GPIO-1:0], st_nxt.mirA};
		if (!blockFollow) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (polarityWrite[i]) begin
					mirNow[i] = outputPolarityBit[i];
				end
			end
		end
		st_nxt.mirA = mirNow[NUM_GPIO-1:0];
		st_nxt.mirB = {{(REG_W-NUM_CH+NUM_GPIO){1'b0}}, mirNow[NUM_CH-1:NUM_GPIO]};

		// per-channel vectors, channel 8 has no sensor
		ltran = {st_r.ltranB[1:0], 1'b0, st_r.ltranA[NUM_SENSE-1:0]};
		grpLinked = st_r.link[LINK_GROUP_BIT];
		linkEff = '0;
		touch   = '0;
		for (int i = 0; i < NUM_SENSE; i++) begin
			linkEff[i] = st_r.link[i] && !chanIsInput[i];
			touch[i]   = detSync[i];
		end
		linkEff[CH_LED10] = grpLinked;
		linkEff[CH_LED9]  = grpLinked;
		touch[CH_LED10]   = detSync[NUM_SENSE];
		touch[CH_LED9]    = detSync[NUM_SENSE+1] && !detSync[NUM_SENSE];

		// last group direction picks the winner for exclusion
		if (detSync[NUM_SENSE]) begin
			st_nxt.lastUp = 1'b1;
		end else if (detSync[NUM_SENSE+1]) begin
			st_nxt.lastUp = 1'b0;
		end

		// handover when a link is made
		rise = linkEff & ~st_r.linkPrev;
		st_nxt.linkPrev = linkEff;
		for (int i = 0; i < NUM_LINK; i++) begin
			if (!linkEff[i]) begin
				st_nxt.holdMode[i] = 1'b0;
			end else if (rise[i] && hostOutputBit[i] && !touch[i]) begin
				st_nxt.holdMode[i] = ltran[i];
			end
		end

		// actuation per channel
		act = hostOutputBit;
		for (int i = 0; i < NUM_LINK; i++) begin
			if (linkEff[i]) begin
				if (st_nxt.holdMode[i]) begin
					act[i] = invFlag ? !touch[i] : 1'b1;
				end else begin
					act[i] = touch[i];
				end
			end
		end
		if (grpLinked && act[CH_LED9] && act[CH_LED10]) begin
			if (st_nxt.lastUp) begin
				act[CH_LED9] = 1'b0;
			end else begin
				act[CH_LED10] = 1'b0;
			end
		end
		act[CH_LED8]  = hostOutputBit[CH_LED8];
		act[CH_LED11] = hostOutputBit[CH_LED11];
		st_nxt.actuate = act;
		st_nxt.autoEn  = linkEff;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata        = {{(DATA_W-REG_W){1'b0}}, st_r.rdata};
	assign pready        = st_r.ready;
	assign pslverr       = st_r.slvErr;
	assign actuate       = st_r.actuate;
	assign autoEnable    = st_r.autoEn;
	assign dutyMirrorBit = {st_r.mirB[NUM_CH-NUM_GPIO-1:0], st_r.mirA};

endmodule

// ===== tb/touch_led_link_control_asserts.sv
// port assertions for the touch-to-light link block
`timescale 1ns/1ps
module touch_led_link_control_asserts
	import tl_link_pkg::*;
(
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                nrst,
	input wire logic                clkEn,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [ADDR_W-1:0]   paddr,
	input wire logic [DATA_W-1:0]   prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// host and drivers
	input wire logic [NUM_CH-1:0]   hostOutputBit,
	input wire logic [NUM_GPIO-1:0] chanIsInput,
	input wire logic [NUM_CH-1:0]   actuate,
	input wire logic [NUM_LINK-1:0] autoEnable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic mapped;
	assign mapped = paddr[9:2] inside {IDX_LTRAN_A, IDX_LTRAN_B, IDX_MIR_A, IDX_MIR_B, IDX_CFG, IDX_LINK};
	property p_excl; !(actuate[CH_LED9] && actuate[CH_LED10]); endproperty
	a_excl: assert property (p_excl) else $error("group channels active together");
	property p_l8; clkEn |=> actuate[CH_LED8] == $past(hostOutputBit[CH_LED8]); endproperty
	a_l8: assert property (p_l8) else $error("channel 8 not following host");
	property p_l11; clkEn |=> actuate[CH_LED11] == $past(hostOutputBit[CH_LED11]); endproperty
	a_l11: assert property (p_l11) else $error("channel 11 not following host");
	property p_aein; clkEn |=> (autoEnable[6:0] & $past(chanIsInput[6:0])) == 7'h00; endproperty
	a_aein: assert property (p_aein) else $error("input channel auto enabled");
	property p_err; pready |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("error response wrong");
	property p_rd0; pready && pslverr |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("apb wait state wrong");
	c_err: cover property (pready && pslverr);
	c_up: cover property (actuate[CH_LED10]);
	c_ae: cover property (autoEnable[0]);
endmodule

// ===== tb/tl_sensor_model.sv
// sensor detector model driving touch and group levels
`timescale 1ns/1ps
module tl_sensor_model
	import tl_link_pkg::*;
(
	// clock
	input wire logic                 clk_sys,
	// commanded levels
	input wire logic [NUM_SENSE-1:0] touchCmd,
	input wire logic                 upCmd,
	input wire logic                 downCmd,
	// detector outputs
	output logic     [NUM_SENSE-1:0] sensorTouch,
	output logic                     groupUp,
	output logic                     groupDown
);
	// a detection reports one direction only
	always @(posedge clk_sys) begin
		sensorTouch <= touchCmd;
		groupUp <= upCmd && !downCmd;
		groupDown <= downCmd && !upCmd;
	end
endmodule

// ===== tb/touch_led_link_control_bench.sv
// self-checking bench for the touch-to-light link block
`timescale 1ns/1ps
module touch_led_link_control_bench import tl_link_pkg::*;;
	logic clk_sys, nrst, clkEn, psel, penable, pwrite, pready, pslverr, er;
	logic upCmd, downCmd, groupUp, groupDown;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata, prdata, rd;
	logic [NUM_CH-1:0]    hostOutputBit, polarityWrite, outputPolarityBit, actuate, dutyMirrorBit;
	logic [NUM_GPIO-1:0]  chanIsInput;
	logic [NUM_SENSE-1:0] touchCmd, sensorTouch;
	logic [NUM_LINK-1:0]  autoEnable;
	logic [7:0]           idxs [6] = '{IDX_LTRAN_A, IDX_LTRAN_B, IDX_MIR_A, IDX_MIR_B, IDX_CFG, IDX_LINK};
	logic [7:0]           masks [6] = '{MASK_LTRAN_A, MASK_LTRAN_B, MASK_MIR_A, MASK_MIR_B, MASK_CFG, MASK_LINK};
	int                   mismatches, num_checks;
	touch_led_link_control touch_led_link_control_inst (.*);
	tl_sensor_model tl_sensor_model_inst (.clk_sys(clk_sys), .touchCmd(touchCmd), .upCmd(upCmd),
		.downCmd(downCmd), .sensorTouch(sensorTouch), .groupUp(groupUp), .groupDown(groupDown));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task automatic settle;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic pol(input logic v);
		outputPolarityBit <= {8'h0, v, 2'h0};
		polarityWrite <= 11'h004;
		@(posedge clk_sys);
		polarityWrite <= 11'h000;
		settle;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		finish_test;
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, upCmd, downCmd, touchCmd} <= '0;
		{hostOutputBit, polarityWrite, outputPolarityBit, chanIsInput} <= '0;
		clkEn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		hostOutputBit <= 11'h401;
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, idxs[k], 8'h00);
			chk(rd, 32'h0);
			wr(idxs[k], 8'hff);
			apb(1'b0, idxs[k], 8'h00);
			chk(rd, 32'(masks[k]));
			wr(idxs[k], 8'h00);
		end
		apb(1'b0, 8'h7c, 8'h00);
		chk(32'(er), 32'h1);
		$display("test registers done");
		settle;
		chk(32'(actuate[0]), 32'h1);
		wr(IDX_LINK, 8'h01);
		settle;
		chk(32'(actuate[0]), 32'h0);
		chk(32'(autoEnable[0]), 32'h1);
		touchCmd <= 7'h03;
		settle;
		chk(32'(actuate[1:0]), 32'h1);
		touchCmd <= 7'h00;
		wr(IDX_LINK, 8'h00);
		wr(IDX_CFG, 8'h01);
		wr(IDX_LTRAN_A, 8'h01);
		wr(IDX_LINK, 8'h01);
		settle;
		chk(32'(actuate[0]), 32'h1);
		touchCmd <= 7'h01;
		settle;
		chk(32'(actuate[0]), 32'h0);
		touchCmd <= 7'h00;
		wr(IDX_LINK, 8'h00);
		wr(IDX_CFG, 8'h00);
		wr(IDX_LINK, 8'h01);
		touchCmd <= 7'h01;
		settle;
		chk(32'(actuate[0]), 32'h1);
		chanIsInput <= 8'h01;
		settle;
		chk(32'(autoEnable[0]), 32'h0);
		{chanIsInput, touchCmd} <= '0;
		$display("test handover done");
		wr(IDX_LINK, 8'h80);
		settle;
		chk(32'(autoEnable[9:8]), 32'h3);
		upCmd <= 1'b1;
		settle;
		chk(32'(actuate[9:8]), 32'h2);
		upCmd <= 1'b0;
		downCmd <= 1'b1;
		settle;
		chk(32'(actuate[9:8]), 32'h1);
		downCmd <= 1'b0;
		$display("test group done");
		clkEn <= 1'b0;
		hostOutputBit <= 11'h400;
		settle;
		chk(32'(actuate[0]), 32'h1);
		clkEn <= 1'b1;
		settle;
		chk(32'(actuate[0]), 32'h0);
		hostOutputBit <= 11'h401;
		$display("test clock enable done");
		wr(IDX_MIR_B, 8'h04);
		settle;
		chk(32'(dutyMirrorBit[10]), 32'h1);
		pol(1'b1);
		apb(1'b0, IDX_MIR_A, 8'h00);
		chk(rd, 32'h4);
		wr(IDX_CFG, 8'h02);
		pol(1'b0);
		chk(32'(dutyMirrorBit[2]), 32'h1);
		wr(IDX_MIR_A, 8'h00);
		settle;
		chk(32'(dutyMirrorBit[2]), 32'h0);
		$display("test mirror done");
		finish_test;
	end
endmodule
bind touch_led_link_control touch_led_link_control_asserts touch_led_link_control_asserts_inst (
	.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .hostOutputBit(hostOutputBit),
	.chanIsInput(chanIsInput), .actuate(actuate), .autoEnable(autoEnable));
